// [design/bpx_pkg.sv]
// Package: opcodes, bit map limits and widths for the bit and move executor
package bpx_pkg;
   localparam int unsigned DATA_W = 8;
   localparam int unsigned ADDR_W = 16;
   // Operation codes presented on op_i
   typedef enum logic [4:0] {
      BPX_NOP        = 5'h00,
      BPX_XRD_IDX    = 5'h01,
      BPX_XWR_IDX    = 5'h02,
      BPX_XRD_DATA_POINTER   = 5'h03,
      BPX_XWR_DATA_POINTER   = 5'h04,
      BPX_CRD_DATA_POINTER   = 5'h05,
      BPX_CRD_PC     = 5'h06,
      BPX_AND_C      = 5'h07,
      BPX_ANDN_C     = 5'h08,
      BPX_OR_C       = 5'h09,
      BPX_ORN_C      = 5'h0A,
      BPX_MOV_TO_C   = 5'h0B,
      BPX_MOV_FROM_C = 5'h0C,
      BPX_CLR_C      = 5'h0D,
      BPX_CLR_BIT    = 5'h0E,
      BPX_SET_C      = 5'h0F,
      BPX_SET_BIT    = 5'h10,
      BPX_CPL_C      = 5'h11,
      BPX_CPL_BIT    = 5'h12,
      BPX_JMP_C      = 5'h13,
      BPX_JMP_NC     = 5'h14,
      BPX_JMP_B      = 5'h15,
      BPX_JMP_NB     = 5'h16,
      BPX_JMP_BC     = 5'h17,
      BPX_XCH        = 5'h18,
      BPX_XCH_LO     = 5'h19,
      BPX_SWAP       = 5'h1A
   } bpx_op_t;
   localparam logic [7:0] SFR_BIT_BASE = 8'h80;
   localparam logic [7:0] STATUS_WORD_ADDR = 8'hD0;
   localparam logic [7:0] RAM_BIT_BYTE_BASE = 8'h20;
   localparam int unsigned CARRY_POS = 7;
   localparam int unsigned RAM_BITS = 128;
endpackage : bpx_pkg

// [design/bpx_exec.sv]
// Executor for external moves, constant reads, bit ops and bit branches
`timescale 1ns/1ps
module bpx_exec (
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire logic start_i,
   input wire logic [4:0] op_i,
   input wire logic [7:0] bit_addr_i,
   input wire logic [7:0] rel_i,
   input wire logic [15:0] next_pc_i,
   input wire logic [15:0] data_pointer_i,
   input wire logic [7:0] index_reg_i,
   input wire logic [7:0] acc_i,
   input wire logic [7:0] psw_i,
   input wire logic [7:0] sfr_byte_i,
   input wire logic [7:0] ram_byte_i,
   input wire logic [7:0] xdata_rdata_i,
   input wire logic [7:0] code_rdata_i,
   output logic busy_o,
   output logic done_o,
   output logic [7:0] acc_o,
   output logic acc_we_o,
   output logic [7:0] psw_o,
   output logic psw_we_o,
   output logic [15:0] pc_o,
   output logic pc_we_o,
   output logic [7:0] byte_addr_o,
   output logic [7:0] byte_wdata_o,
   output logic sfr_we_o,
   output logic ram_we_o,
   output logic [15:0] xdata_addr_o,
   output logic [7:0] xdata_wdata_o,
   output logic xdata_rd_o,
   output logic xdata_wr_o,
   output logic [15:0] code_addr_o,
   output logic code_rd_o
);
   typedef enum logic [1:0] {
      BPX_IDLE,
      BPX_FETCH,
      BPX_FINISH
   } bpx_state_t;

   // Byte that holds a given bit: RAM page or bit-addressable register
   function automatic logic [7:0] bpx_byte_of(input logic [7:0] ba);
      if (ba < bpx_pkg::SFR_BIT_BASE) begin
         return bpx_pkg::RAM_BIT_BYTE_BASE + {4'h0, ba[6:3]};
      end
      return {ba[7:3], 3'h0};
   endfunction : bpx_byte_of

   bpx_state_t state;
   bpx_state_t next_state;
   bpx_pkg::bpx_op_t op;
   bpx_pkg::bpx_op_t next_op;
   logic [7:0] bit_addr;
   logic [7:0] next_bit_addr;
   logic busy, next_busy, done, next_done;
   logic [7:0] acc, next_acc;
   logic acc_we, next_acc_we;
   logic [7:0] program_status_word, next_psw;
   logic psw_we, next_psw_we;
   logic [15:0] pc, next_pc;
   logic pc_we, next_pc_we;
   logic [7:0] byte_addr, next_byte_addr;
   logic [7:0] byte_wdata, next_byte_wdata;
   logic sfr_we, next_sfr_we, ram_we, next_ram_we;
   logic [15:0] xaddr, next_xaddr;
   logic [7:0] xwdata, next_xwdata;
   logic xrd, next_xrd, xwr, next_xwr;
   logic [15:0] caddr, next_caddr;
   logic crd, next_crd;

   // Operand bit and its containing byte, both decoded from the direct address
   logic [7:0] src_byte;
   logic is_psw;
   logic bitv;
   logic carry;
   logic newbit;
   logic write_bit;
   logic taken;
   logic [7:0] wb;

   always_comb begin
      next_state = state;
      next_op = op;
      next_bit_addr = bit_addr;
      next_busy = busy;
      next_done = 1'b0;
      next_acc = acc;
      next_acc_we = 1'b0;
      next_psw = program_status_word;
      next_psw_we = 1'b0;
      next_pc = pc;
      next_pc_we = 1'b0;
      next_byte_addr = byte_addr;
      next_byte_wdata = byte_wdata;
      next_sfr_we = 1'b0;
      next_ram_we = 1'b0;
      next_xaddr = xaddr;
      next_xwdata = xwdata;
      next_xrd = 1'b0;
      next_xwr = 1'b0;
      next_caddr = caddr;
      next_crd = 1'b0;
      is_psw = bpx_byte_of(bit_addr) == bpx_pkg::STATUS_WORD_ADDR;
      src_byte = bit_addr < bpx_pkg::SFR_BIT_BASE ? ram_byte_i
                 : (is_psw ? psw_i : sfr_byte_i);
      bitv = src_byte[bit_addr[2:0]];
      carry = psw_i[bpx_pkg::CARRY_POS];
      newbit = bitv;
      write_bit = 1'b0;
      taken = 1'b0;
      wb = src_byte;
      unique case (state)
         BPX_IDLE: begin
            if (start_i) begin
               next_op = bpx_pkg::bpx_op_t'(op_i);
               next_bit_addr = bit_addr_i;
               next_byte_addr = bpx_byte_of(bit_addr_i);
               next_busy = 1'b1;
               next_state = BPX_FETCH;
               unique case (bpx_pkg::bpx_op_t'(op_i))
                  bpx_pkg::BPX_XRD_IDX, bpx_pkg::BPX_XWR_IDX,
                  bpx_pkg::BPX_XCH, bpx_pkg::BPX_XCH_LO: begin
                     next_byte_addr = index_reg_i;
                     next_xaddr = {8'h00, index_reg_i};
                  end
                  default: begin
                     next_xaddr = data_pointer_i;
                  end
               endcase
               next_xwdata = acc_i;
               next_xrd = op_i == bpx_pkg::BPX_XRD_IDX
                          || op_i == bpx_pkg::BPX_XRD_DATA_POINTER;
               next_xwr = op_i == bpx_pkg::BPX_XWR_IDX
                          || op_i == bpx_pkg::BPX_XWR_DATA_POINTER;
               // Only a read strobe exists toward program memory
               next_caddr = op_i == bpx_pkg::BPX_CRD_PC
                  ? next_pc_i + {8'h00, acc_i}
                  : data_pointer_i + {8'h00, acc_i};
               next_crd = op_i == bpx_pkg::BPX_CRD_PC
                          || op_i == bpx_pkg::BPX_CRD_DATA_POINTER;
            end
         end
         BPX_FETCH: begin
            // Memory answers one cycle after its strobe
            next_state = BPX_FINISH;
         end
         BPX_FINISH: begin
            next_state = BPX_IDLE;
            next_busy = 1'b0;
            next_done = 1'b1;
            next_psw = psw_i;
            unique case (op)
               bpx_pkg::BPX_XRD_IDX, bpx_pkg::BPX_XRD_DATA_POINTER: begin
                  next_acc = xdata_rdata_i;
                  next_acc_we = 1'b1;
               end
               bpx_pkg::BPX_CRD_DATA_POINTER, bpx_pkg::BPX_CRD_PC: begin
                  next_acc = code_rdata_i;
                  next_acc_we = 1'b1;
               end
               bpx_pkg::BPX_AND_C: next_psw[bpx_pkg::CARRY_POS] = carry & bitv;
               bpx_pkg::BPX_ANDN_C: next_psw[bpx_pkg::CARRY_POS] = carry & ~bitv;
               bpx_pkg::BPX_OR_C: next_psw[bpx_pkg::CARRY_POS] = carry | bitv;
               bpx_pkg::BPX_ORN_C: next_psw[bpx_pkg::CARRY_POS] = carry | ~bitv;
               bpx_pkg::BPX_MOV_TO_C: next_psw[bpx_pkg::CARRY_POS] = bitv;
               bpx_pkg::BPX_CLR_C: next_psw[bpx_pkg::CARRY_POS] = 1'b0;
               bpx_pkg::BPX_SET_C: next_psw[bpx_pkg::CARRY_POS] = 1'b1;
               bpx_pkg::BPX_CPL_C: next_psw[bpx_pkg::CARRY_POS] = ~carry;
               bpx_pkg::BPX_MOV_FROM_C: begin
                  newbit = carry;
                  write_bit = 1'b1;
               end
               bpx_pkg::BPX_CLR_BIT: begin
                  newbit = 1'b0;
                  write_bit = 1'b1;
               end
               bpx_pkg::BPX_SET_BIT: begin
                  newbit = 1'b1;
                  write_bit = 1'b1;
               end
               bpx_pkg::BPX_CPL_BIT: begin
                  newbit = ~bitv;
                  write_bit = 1'b1;
               end
               bpx_pkg::BPX_JMP_C: taken = carry;
               bpx_pkg::BPX_JMP_NC: taken = ~carry;
               bpx_pkg::BPX_JMP_B: taken = bitv;
               bpx_pkg::BPX_JMP_NB: taken = ~bitv;
               bpx_pkg::BPX_JMP_BC: begin
                  taken = bitv;
                  newbit = 1'b0;
                  write_bit = bitv;
               end
               bpx_pkg::BPX_XCH: begin
                  next_acc = ram_byte_i;
                  next_acc_we = 1'b1;
                  next_byte_wdata = acc_i;
                  next_ram_we = 1'b1;
               end
               bpx_pkg::BPX_XCH_LO: begin
                  next_acc = {acc_i[7:4], ram_byte_i[3:0]};
                  next_acc_we = 1'b1;
                  next_byte_wdata = {ram_byte_i[7:4], acc_i[3:0]};
                  next_ram_we = 1'b1;
               end
               bpx_pkg::BPX_SWAP: begin
                  next_acc = {acc_i[3:0], acc_i[7:4]};
                  next_acc_we = 1'b1;
               end
               default: begin
               end
            endcase
            wb[bit_addr[2:0]] = newbit;
            if (write_bit) begin
               // Read-modify-write touches only the addressed bit
               if (is_psw) begin
                  next_psw = wb;
               end else if (bit_addr < bpx_pkg::SFR_BIT_BASE) begin
                  next_byte_wdata = wb;
                  next_ram_we = 1'b1;
               end else begin
                  next_byte_wdata = wb;
                  next_sfr_we = 1'b1;
               end
            end
            next_psw_we = next_psw != psw_i;
            // Untaken leaves the counter at the following instruction
            next_pc = next_pc_i + {{8{rel_i[7]}}, rel_i};
            next_pc_we = taken;
         end
         default: begin
            next_state = BPX_IDLE;
            next_busy = 1'b0;
         end
      endcase
   end

   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         state <= BPX_IDLE;
         op <= bpx_pkg::BPX_NOP;
         bit_addr <= 8'h00;
         busy <= 1'b0;
         done <= 1'b0;
         acc <= 8'h00;
         acc_we <= 1'b0;
         program_status_word <= 8'h00;
         psw_we <= 1'b0;
         pc <= 16'h0000;
         pc_we <= 1'b0;
         byte_addr <= 8'h00;
         byte_wdata <= 8'h00;
         sfr_we <= 1'b0;
         ram_we <= 1'b0;
         xaddr <= 16'h0000;
         xwdata <= 8'h00;
         xrd <= 1'b0;
         xwr <= 1'b0;
         caddr <= 16'h0000;
         crd <= 1'b0;
      end else begin
         state <= next_state;
         op <= next_op;
         bit_addr <= next_bit_addr;
         busy <= next_busy;
         done <= next_done;
         acc <= next_acc;
         acc_we <= next_acc_we;
         program_status_word <= next_psw;
         psw_we <= next_psw_we;
         pc <= next_pc;
         pc_we <= next_pc_we;
         byte_addr <= next_byte_addr;
         byte_wdata <= next_byte_wdata;
         sfr_we <= next_sfr_we;
         ram_we <= next_ram_we;
         xaddr <= next_xaddr;
         xwdata <= next_xwdata;
         xrd <= next_xrd;
         xwr <= next_xwr;
         caddr <= next_caddr;
         crd <= next_crd;
      end
   end

   assign busy_o = busy;
   assign done_o = done;
   assign acc_o = acc;
   assign acc_we_o = acc_we;
   assign psw_o = program_status_word;
   assign psw_we_o = psw_we;
   assign pc_o = pc;
   assign pc_we_o = pc_we;
   assign byte_addr_o = byte_addr;
   assign byte_wdata_o = byte_wdata;
   assign sfr_we_o = sfr_we;
   assign ram_we_o = ram_we;
   assign xdata_addr_o = xaddr;
   assign xdata_wdata_o = xwdata;
   assign xdata_rd_o = xrd;
   assign xdata_wr_o = xwr;
   assign code_addr_o = caddr;
   assign code_rd_o = crd;
endmodule : bpx_exec

// [testbench/bpx_exec_monitor.sv]
// Port timing checker of the bit and move executor
`timescale 1ns/1ps
module bpx_exec_chk (
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire logic start_i,
   input wire logic [4:0] op_i,
   input wire logic [7:0] acc_i,
   input wire logic [15:0] data_pointer_i,
   input wire logic [15:0] next_pc_i,
   input wire logic [7:0] index_reg_i,
   input wire logic [7:0] rel_i,
   input wire logic busy_o,
   input wire logic done_o,
   input wire logic [15:0] pc_o,
   input wire logic pc_we_o,
   input wire logic acc_we_o,
   input wire logic [15:0] xdata_addr_o,
   input wire logic [7:0] xdata_wdata_o,
   input wire logic xdata_rd_o,
   input wire logic xdata_wr_o,
   input wire logic [15:0] code_addr_o,
   input wire logic code_rd_o
);
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rst_n_i);
   wire take = start_i && !busy_o;
   wire xrd = op_i == bpx_pkg::BPX_XRD_IDX || op_i == bpx_pkg::BPX_XRD_DATA_POINTER;
   wire xwr = op_i == bpx_pkg::BPX_XWR_IDX || op_i == bpx_pkg::BPX_XWR_DATA_POINTER;
   wire crd = op_i == bpx_pkg::BPX_CRD_DATA_POINTER || op_i == bpx_pkg::BPX_CRD_PC;
   sequence busy_run;
      busy_o ##1 busy_o ##1 done_o;
   endsequence
   sequence acc_load;
      ##2 acc_we_o && done_o;
   endsequence
   busy_done_a: assert property (take |=> busy_run)
      else $error("done not three cycles after start");
   xrd_index_a: assert property (take && op_i == bpx_pkg::BPX_XRD_IDX
      |=> xdata_rd_o && xdata_addr_o == {8'h00, index_reg_i})
      else $error("external read address not index register");
   xrd_pointer_a: assert property (take && op_i == bpx_pkg::BPX_XRD_DATA_POINTER
      |=> xdata_rd_o && xdata_addr_o == data_pointer_i)
      else $error("external read address not data pointer");
   xwr_source_a: assert property (take && xwr
      |=> xdata_wr_o && xdata_wdata_o == acc_i)
      else $error("external write data not accumulator");
   xrd_dest_a: assert property (take && xrd |=> acc_load)
      else $error("external read not loaded to accumulator");
   cdptr_addr_a: assert property (take && op_i == bpx_pkg::BPX_CRD_DATA_POINTER
      |=> code_rd_o && code_addr_o == data_pointer_i + {8'h00, acc_i})
      else $error("pointer constant address wrong");
   cpc_addr_a: assert property (take && op_i == bpx_pkg::BPX_CRD_PC
      |=> code_rd_o && code_addr_o == next_pc_i + {8'h00, acc_i})
      else $error("counter constant address wrong");
   code_readonly_a: assert property (take && crd
      |=> !xdata_wr_o && !xdata_rd_o ##0 acc_load)
      else $error("constant read touched data memory");
   branch_target_a: assert property (pc_we_o |-> done_o
      && pc_o == next_pc_i + {{8{rel_i[7]}}, rel_i})
      else $error("branch target wrong");
endmodule : bpx_exec_chk

bind bpx_exec bpx_exec_chk bpx_exec_chk_i (.mclk_i, .rst_n_i, .start_i,
   .op_i, .acc_i, .data_pointer_i, .next_pc_i, .index_reg_i, .rel_i, .busy_o,
   .done_o, .pc_o, .pc_we_o, .acc_we_o, .xdata_addr_o, .xdata_wdata_o,
   .xdata_rd_o, .xdata_wr_o, .code_addr_o, .code_rd_o);

// [testbench/bpx_mem_model.sv]
// Model of external data memory and program memory
`timescale 1ns/1ps
module bpx_mem_model (
   input wire logic mclk_i,
   input wire logic [15:0] xaddr_i,
   input wire logic [7:0] xwdata_i,
   input wire logic xrd_i,
   input wire logic xwr_i,
   input wire logic [15:0] caddr_i,
   input wire logic crd_i,
   output logic [7:0] xrdata_o,
   output logic [7:0] crdata_o
);
   logic [7:0] xmem [0:255];
   initial begin
      xrdata_o = 8'h00;
      crdata_o = 8'h00;
      for (int k = 0; k < 256; k++) begin
         xmem[k] = 8'(k) ^ 8'h5A;
      end
   end
   // Data lives one cycle, then flips so a late sample shows up
   always @(posedge mclk_i) begin
      xrdata_o <= xrd_i ? xmem[xaddr_i[7:0]] : ~xrdata_o;
      // No write path into program memory
      crdata_o <= crd_i ? caddr_i[7:0] ^ caddr_i[15:8] ^ 8'hC3 : ~crdata_o;
      if (xwr_i) begin
         xmem[xaddr_i[7:0]] <= xwdata_i;
      end
   end
endmodule : bpx_mem_model

// [testbench/bpx_exec_tb.sv]
// Self-checking bench of the bit and move executor
`timescale 1ns/1ps
module bpx_exec_tb;
   logic mclk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic start_i = 1'b0;
   logic [4:0] op_i = 5'h00;
   logic [7:0] bit_addr_i = 8'h00, rel_i = 8'h00, index_reg_i = 8'h00;
   logic [7:0] acc_i = 8'h00, psw_i = 8'h00;
   logic [7:0] sfr_byte_i = 8'h00, ram_byte_i = 8'h00;
   logic [15:0] next_pc_i = 16'h1000, data_pointer_i = 16'h0000;
   wire logic [7:0] xdata_rdata_i, code_rdata_i;
   logic busy_o, done_o, acc_we_o, psw_we_o, pc_we_o, sfr_we_o, ram_we_o;
   logic xdata_rd_o, xdata_wr_o, code_rd_o;
   logic [7:0] acc_o, psw_o, byte_addr_o, byte_wdata_o, xdata_wdata_o;
   logic [15:0] pc_o, xdata_addr_o, code_addr_o;
   int err_count = 0;
   int cmp_count = 0;
   int cycles = 0;
   bpx_exec bpx_exec_i (.mclk_i, .rst_n_i, .start_i, .op_i, .bit_addr_i,
      .rel_i, .next_pc_i, .data_pointer_i, .index_reg_i, .acc_i, .psw_i, .sfr_byte_i,
      .ram_byte_i, .xdata_rdata_i, .code_rdata_i, .busy_o, .done_o, .acc_o,
      .acc_we_o, .psw_o, .psw_we_o, .pc_o, .pc_we_o, .byte_addr_o,
      .byte_wdata_o, .sfr_we_o, .ram_we_o, .xdata_addr_o, .xdata_wdata_o,
      .xdata_rd_o, .xdata_wr_o, .code_addr_o, .code_rd_o);
   bpx_mem_model bpx_mem_model_i (.mclk_i, .xaddr_i(xdata_addr_o),
      .xwdata_i(xdata_wdata_o), .xrd_i(xdata_rd_o), .xwr_i(xdata_wr_o),
      .caddr_i(code_addr_o), .crd_i(code_rd_o), .xrdata_o(xdata_rdata_i),
      .crdata_o(code_rdata_i));
   always #20 mclk_i = ~mclk_i;
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : complete_run
   always @(posedge mclk_i) begin
      cycles++;
      if (cycles == 2000) begin
         err_count++;
         complete_run();
      end
   end
   task automatic check(input string what, input logic [63:0] seen, want);
      cmp_count++;
      if (seen !== want) begin
         err_count++;
         $display("unexpected %s expected %h seen %h", what, want, seen);
      end
   endtask : check
   // Result packs status, accumulator, byte write and branch in one word
   task automatic do_op(input logic [4:0] op, input logic [47:0] stim,
         input logic [55:0] want);
      logic [15:0] wr;
      logic [55:0] seen;
      @(posedge mclk_i);
      op_i <= op;
      {bit_addr_i, rel_i, psw_i, acc_i, ram_byte_i, sfr_byte_i} <= stim;
      start_i <= 1'b1;
      @(posedge mclk_i);
      start_i <= 1'b0;
      // Done and the byte, status, accumulator and counter write pulses stand only
      // between the second and third edges after the start edge
      repeat (2) @(posedge mclk_i);
      #1;
      check("done", {63'h0, done_o}, 64'h1);
      wr = (ram_we_o | sfr_we_o) ? {byte_addr_o, byte_wdata_o} : 16'h0000;
      seen = {psw_we_o ? psw_o : psw_i, acc_we_o ? acc_o : acc_i, 2'b00,
         ram_we_o, sfr_we_o, wr, 3'b000, pc_we_o, pc_we_o ? pc_o : 16'h0};
      check("result", {8'h00, seen}, {8'h00, want});
      // Return on an edge so that callers change inputs at the clock edge
      @(posedge mclk_i);
   endtask : do_op
   task automatic t_xdata();
      @(posedge mclk_i);
      index_reg_i <= 8'h34;
      data_pointer_i <= 16'h0034;
      do_op(bpx_pkg::BPX_XWR_IDX, 48'h0000005A0000,
         56'h005A0000000000);
      do_op(bpx_pkg::BPX_XRD_DATA_POINTER, 48'h0, 56'h005A0000000000);
      data_pointer_i <= 16'h0040;
      index_reg_i <= 8'h40;
      do_op(bpx_pkg::BPX_XWR_DATA_POINTER, 48'h000000C30000,
         56'h00C30000000000);
      do_op(bpx_pkg::BPX_XRD_IDX, 48'h0, 56'h00C30000000000);
   endtask : t_xdata
   task automatic t_code();
      data_pointer_i <= 16'h1F02;
      do_op(bpx_pkg::BPX_CRD_DATA_POINTER, 48'h000000FF0000,
         56'h00E20000000000);
      next_pc_i <= 16'h00FF;
      // Index one, so the sum with the counter carries into the upper address byte
      do_op(bpx_pkg::BPX_CRD_PC, 48'h000000010000,
         56'h00C20000000000);
      next_pc_i <= 16'h1000;
   endtask : t_code
   task automatic t_bits();
      do_op(bpx_pkg::BPX_AND_C, 48'h0B0080000000, 56'h0);
      do_op(bpx_pkg::BPX_ANDN_C, 48'h0B0080000000, 56'h80000000000000);
      do_op(bpx_pkg::BPX_OR_C, 48'h0B0000000800, 56'h80000000000000);
      do_op(bpx_pkg::BPX_ORN_C, 48'h0B0000000800, 56'h0);
      do_op(bpx_pkg::BPX_MOV_TO_C, 48'h930000000008,
         56'h80000000000000);
      do_op(bpx_pkg::BPX_MOV_FROM_C, 48'h930080000000,
         56'h80001900800000);
      do_op(bpx_pkg::BPX_CLR_C, 48'h000081000000,
         56'h01000000000000);
      do_op(bpx_pkg::BPX_CLR_BIT, 48'h0B000000FF00,
         56'h0000221F700000);
      do_op(bpx_pkg::BPX_SET_C, 48'h0, 56'h80000000000000);
      do_op(bpx_pkg::BPX_SET_BIT, 48'h7F0000000000,
         56'h000022F8000000);
      do_op(bpx_pkg::BPX_CPL_C, 48'h000080000000, 56'h0);
      do_op(bpx_pkg::BPX_CPL_BIT, 48'h800000000001,
         56'h00001800000000);
      do_op(bpx_pkg::BPX_SET_BIT, 48'hD70000000000,
         56'h80000000000000);
      do_op(bpx_pkg::BPX_CPL_BIT, 48'hD00000000000,
         56'h01000000000000);
   endtask : t_bits
   task automatic t_jumps();
      do_op(bpx_pkg::BPX_JMP_C, 48'h008080000000,
         56'h80000000010F80);
      do_op(bpx_pkg::BPX_JMP_NC, 48'h000580000000,
         56'h80000000000000);
      do_op(bpx_pkg::BPX_JMP_B, 48'h0B7F00000800,
         56'h0000000001107F);
      do_op(bpx_pkg::BPX_JMP_NB, 48'h0BFF00000000,
         56'h00000000010FFF);
      do_op(bpx_pkg::BPX_JMP_BC, 48'h0B1000000800,
         56'h00002210011010);
      do_op(bpx_pkg::BPX_JMP_BC, 48'h0B100000F700, 56'h0);
      do_op(bpx_pkg::BPX_JMP_B, 48'hD20204000000,
         56'h04000000011002);
   endtask : t_jumps
   task automatic t_exch();
      index_reg_i <= 8'h2D;
      do_op(bpx_pkg::BPX_XCH, 48'h000000123400, 56'h003422D1200000);
      do_op(bpx_pkg::BPX_XCH_LO, 48'h000000785600,
         56'h007622D5800000);
      do_op(bpx_pkg::BPX_SWAP, 48'h000000670000, 56'h00760000000000);
   endtask : t_exch
   initial begin
      repeat (4) @(posedge mclk_i);
      rst_n_i <= 1'b1;
      #1;
      check("idle", {62'h0, busy_o, done_o}, 64'h0);
      t_xdata();
      t_code();
      t_bits();
      t_jumps();
      t_exch();
      complete_run();
   end
endmodule : bpx_exec_tb
